// >>> rtl/svrs_voltage_select.sv
// standby/run target level select for the four slewing regulator rails
// How it works
// - standby pin high slews rails to standby
// - standby pin low slews rails to run
// - equal run and standby codes mean no slew
// - all target levels reset to 0x19
// - codes up to 0x1f accepted and applied
// - spare bits hold hibernate state for readback
// - keep-alive keeps one buck on in hibernate
// - host programs levels and changes via serial port
`timescale 1ns/1ns
`default_nettype none
`include "svrs_cfg.svh"
module svrs_voltage_select
  import svrs_pkg::*;
#(
  parameter int RAILS = `SVRS_RAILS,
  parameter int CODE_W = `SVRS_CODE_W,
  parameter int SPARE_W = `SVRS_SPARE_W,
  parameter int STEP_CYCLES = `SVRS_SLEW_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clockEnable,
  input wire logic standbySelectPin,
  input wire logic [RAILS-1:0] runLevelWrite,
  input wire logic [RAILS-1:0] standbyLevelWrite,
  input wire logic [CODE_W-1:0] levelWriteData,
  input wire logic spareWrite,
  input wire logic [SPARE_W-1:0] spareWriteData,
  input wire logic hibernate,
  input wire logic bucKeepAliveSet,
  input wire logic [RAILS-1:0] bucEnableRequest,
  output logic [RAILS*CODE_W-1:0] runTargetLevel,
  output logic [RAILS*CODE_W-1:0] standbyTargetLevel,
  output logic [RAILS*CODE_W-1:0] railReference,
  output logic [RAILS-1:0] railSlewing,
  output logic [SPARE_W-1:0] spareBits,
  output logic [RAILS-1:0] railEnable
);
  logic [CODE_W-1:0] runLevel_reg [RAILS];   // run target level per rail
  logic [CODE_W-1:0] stbyLevel_reg [RAILS];  // standby target level per rail
  logic [SPARE_W-1:0] spare_reg;             // scratch for hibernate/resume state
  logic keepAlive_reg;                       // keep-alive armed for rail 0 buck
  logic [RAILS-1:0] railEnable_reg;          // registered rail enables

  // block overview
  // the host side of the serial port is decoded upstream; this block only sees
  // one-cycle write strobes per rail and per level, plus a shared data word.
  // a run write and a standby write in the same cycle both take that word,
  // so a host that wants different codes must spend two cycles.
  // each rail keeps two codes: the run level and the standby level.
  // the standby select pin picks one of them for all rails at once.
  // the chosen code is the target of a slewing reference, one per rail,
  // which walks one lsb per step toward it.
  // equal run and standby codes mean the pin has no visible effect,
  // which is the state after reset.
  // the pin is taken as synchronous; a raw pad must be synchronised outside.
  // the slewing reference follows the live target, so a pin change in the
  // middle of a slew turns the rail around without waiting for the old slew.
  // the step counter is not cleared on such a turn; the first step after it
  // may come early, traded for a simpler counter.
  // the clock enable freezes every register of this block and of the slews,
  // writes included; a strobe seen while it is low is lost, not queued.
  // the spare bits have no regulator function at all; they only hold what
  // the host wrote so it can read its hibernate state back later.
  // during hibernate every rail enable drops except rail 0, which stays on
  // when the keep-alive arm bit is set and its enable is still requested.
  // the arm bit is registered, so a change of it reaches the rail enable
  // two edges after the input moves.
  // the rail enables are registered so the regulators never see a glitch
  // from the decoder upstream.
  // codes are clamped to the maximum on write; at the documented width the
  // clamp is a no-op but it protects a build with a wider code.

  // clamp writes to the maximum code; width already caps it, kept for narrower maxima
  function automatic logic [CODE_W-1:0] clampCode(input logic [CODE_W-1:0] c);
    clampCode = (c > `SVRS_CODE_MAX) ? `SVRS_CODE_MAX : c;
  endfunction

  // per-rail target storage and slewing reference
  for (genvar r = 0; r < RAILS; r++) begin : g_rail
    logic [CODE_W-1:0] selTarget; // level chosen by the pin

    // target level registers, written by the serial-port decoder upstream
    always_ff @(posedge clock) begin
      if (!rst_b) begin
        runLevel_reg[r] <= `SVRS_CODE_DEFAULT;
        stbyLevel_reg[r] <= `SVRS_CODE_DEFAULT;
      end else if (clockEnable) begin
        if (runLevelWrite[r]) runLevel_reg[r] <= clampCode(levelWriteData);
        if (standbyLevelWrite[r]) stbyLevel_reg[r] <= clampCode(levelWriteData);
      end
    end

    // the pin picks the set point; equal codes make the choice invisible
    assign selTarget = standbySelectPin ? stbyLevel_reg[r] : runLevel_reg[r];

    svrs_rail_slew #(.CODE_W(CODE_W), .STEP_CYCLES(STEP_CYCLES)) u_slew (
      .clock(clock),
      .rst_b(rst_b),
      .clockEnable(clockEnable),
      .targetCode(selTarget),
      .railCode(railReference[r*CODE_W +: CODE_W]),
      .railSlewing(railSlewing[r])
    );

    assign runTargetLevel[r*CODE_W +: CODE_W] = runLevel_reg[r];
    assign standbyTargetLevel[r*CODE_W +: CODE_W] = stbyLevel_reg[r];

    // rail reaches the standby code while the pin is held
    a_stby_reach: assert property (@(posedge clock) disable iff (!rst_b)
      clockEnable && standbySelectPin && $stable(stbyLevel_reg[r]) && !railSlewing[r]
      |-> railReference[r*CODE_W +: CODE_W] == stbyLevel_reg[r])
      else $error("settled rail not at standby level");
    // rail reaches the run code while the pin is low
    a_run_reach: assert property (@(posedge clock) disable iff (!rst_b)
      !standbySelectPin && !railSlewing[r]
      |-> railReference[r*CODE_W +: CODE_W] == runLevel_reg[r])
      else $error("settled rail not at run level");
    // a written code shows in the register one cycle later
    a_level_write: assert property (@(posedge clock) disable iff (!rst_b)
      clockEnable && runLevelWrite[r] |=> runLevel_reg[r] == $past(levelWriteData))
      else $error("run level write not applied");
    // a written standby code shows one cycle later
    a_stby_write: assert property (@(posedge clock) disable iff (!rst_b)
      clockEnable && standbyLevelWrite[r] |=> stbyLevel_reg[r] == $past(levelWriteData))
      else $error("standby level write not applied");
    // disabled clock leaves both levels untouched
    a_level_freeze: assert property (@(posedge clock) disable iff (!rst_b)
      !clockEnable |=> $stable(runLevel_reg[r]) && $stable(stbyLevel_reg[r]))
      else $error("level changed with clock disabled");
    // disabled clock leaves the slewing reference untouched
    a_ref_freeze: assert property (@(posedge clock) disable iff (!rst_b)
      !clockEnable |=> $stable(railReference[r*CODE_W +: CODE_W]))
      else $error("reference moved with clock disabled");
    // the reference never passes the maximum code
    a_ref_range: assert property (@(posedge clock) disable iff (!rst_b)
      railReference[r*CODE_W +: CODE_W] <= `SVRS_CODE_MAX)
      else $error("reference above maximum code");
    // slewing flag means the reference is off the selected target
    a_slew_flag: assert property (@(posedge clock) disable iff (!rst_b)
      railSlewing[r] == (railReference[r*CODE_W +: CODE_W] != selTarget))
      else $error("slewing flag disagrees with target");
  end

  // spare bookkeeping bits, no regulator function
  always_ff @(posedge clock) begin
    if (!rst_b) spare_reg <= '0;
    else if (clockEnable && spareWrite) spare_reg <= spareWriteData;
  end
  assign spareBits = spare_reg;

  // keep-alive arm bit for the memory buck on rail 0
  always_ff @(posedge clock) begin
    if (!rst_b) keepAlive_reg <= 1'b0;
    else if (clockEnable) keepAlive_reg <= bucKeepAliveSet;
  end

  // hibernate drops every rail except a kept-alive rail 0, so memory survives
  always_ff @(posedge clock) begin
    if (!rst_b) railEnable_reg <= '0;
    else if (clockEnable) begin
      if (hibernate) railEnable_reg <= {{(RAILS-1){1'b0}}, bucEnableRequest[0] & keepAlive_reg};
      else railEnable_reg <= bucEnableRequest;
    end
  end
  assign railEnable = railEnable_reg;

  // kept-alive memory rail stays on through hibernate
  a_keep_alive: assert property (@(posedge clock) disable iff (!rst_b)
    clockEnable && hibernate && keepAlive_reg && bucEnableRequest[0] |=> railEnable[0])
    else $error("kept-alive rail dropped in hibernate");
  // spare bits read back what was written
  a_spare_back: assert property (@(posedge clock) disable iff (!rst_b)
    clockEnable && spareWrite |=> spareBits == $past(spareWriteData))
    else $error("spare bits not read back");
  // only rail 0 may stay on in hibernate
  a_hib_off: assert property (@(posedge clock) disable iff (!rst_b)
    clockEnable && hibernate |=> railEnable[RAILS-1:1] == '0)
    else $error("rail left on in hibernate");
  // out of hibernate the enables follow the request
  a_enable_follow: assert property (@(posedge clock) disable iff (!rst_b)
    clockEnable && !hibernate |=> railEnable == $past(bucEnableRequest))
    else $error("rail enable not following request");
  // the arm bit tracks its input each enabled cycle
  a_keep_arm: assert property (@(posedge clock) disable iff (!rst_b)
    clockEnable |=> keepAlive_reg == $past(bucKeepAliveSet))
    else $error("keep-alive arm not registered");
  // disabled clock freezes enables and spare bits
  a_out_freeze: assert property (@(posedge clock) disable iff (!rst_b)
    !clockEnable |=> $stable(railEnable) && $stable(spareBits))
    else $error("output register moved with clock disabled");
endmodule
`default_nettype wire

// >>> rtl/svrs_cfg.svh
// constants for the standby/run voltage select block
`ifndef SVRS_CFG_SVH
`define SVRS_CFG_SVH
`define SVRS_CODE_DEFAULT 5'h19
`define SVRS_CODE_MAX 5'h1f
`define SVRS_RAILS 4
`define SVRS_CODE_W 5
`define SVRS_SPARE_W 8
`define SVRS_SLEW_STEP_NS 1000
`define SVRS_CLK_NS 100
`define SVRS_SLEW_CYCLES ((`SVRS_SLEW_STEP_NS + `SVRS_CLK_NS - 1) / `SVRS_CLK_NS)
`endif

// >>> rtl/svrs_pkg.sv
// types for the standby/run voltage select block
package svrs_pkg;
  typedef enum logic [1:0] {SVRS_IDLE, SVRS_UP, SVRS_DOWN} svrs_slew_t;
endpackage

// >>> rtl/svrs_rail_slew.sv
// one rail's slewing reference: steps toward its selected target
`timescale 1ns/1ns
`default_nettype none
`include "svrs_cfg.svh"
module svrs_rail_slew
  import svrs_pkg::*;
#(
  parameter int CODE_W = `SVRS_CODE_W,
  parameter int STEP_CYCLES = `SVRS_SLEW_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clockEnable,
  input wire logic [CODE_W-1:0] targetCode,
  output logic [CODE_W-1:0] railCode,
  output logic railSlewing
);
  svrs_slew_t dir;
  logic [15:0] tick_reg;
  logic [CODE_W-1:0] code_reg;
  logic stepNow;

  // direction follows the live target, so a change mid-slew retargets at once
  always_comb begin
    if (targetCode > code_reg) dir = SVRS_UP;
    else if (targetCode < code_reg) dir = SVRS_DOWN;
    else dir = SVRS_IDLE;
  end
  assign stepNow = (tick_reg == 16'(STEP_CYCLES - 1));

  // step pacing counter, held at zero while settled
  always_ff @(posedge clock) begin
    if (!rst_b) tick_reg <= 16'h0000;
    else if (clockEnable) begin
      if (dir == SVRS_IDLE || stepNow) tick_reg <= 16'h0000;
      else tick_reg <= tick_reg + 16'h0001;
    end
  end

  // reference code, one lsb per step
  always_ff @(posedge clock) begin
    if (!rst_b) code_reg <= `SVRS_CODE_DEFAULT;
    else if (clockEnable && stepNow) begin
      unique case (dir)
        SVRS_UP: code_reg <= code_reg + 1'b1;
        SVRS_DOWN: code_reg <= code_reg - 1'b1;
        SVRS_IDLE: code_reg <= code_reg;
      endcase
    end
  end
  assign railCode = code_reg;
  assign railSlewing = (dir != SVRS_IDLE);

  // a settled rail never moves
  a_settled_hold: assert property (@(posedge clock) disable iff (!rst_b)
    (targetCode == railCode) && $stable(targetCode) |=> $stable(railCode))
    else $error("settled rail code moved");
  // steps are exactly one lsb
  a_step_size: assert property (@(posedge clock) disable iff (!rst_b)
    !$stable(railCode) |-> (railCode == $past(railCode) + 1'b1) || (railCode == $past(railCode) - 1'b1))
    else $error("rail code jumped more than one step");
endmodule
`default_nettype wire

// >>> test/svrs_host_model.sv
// processor-side model driving the standby select pin
`timescale 1ns/1ns
`default_nettype none
module svrs_host_model (
  input wire logic clock,
  input wire logic wantStandby,
  output logic standbySelectPin
);
  logic pinReg = 1'b0; // pin starts low, selecting run
  assign standbySelectPin = pinReg;
  // pin moves just after an edge, as a gpio would
  always @(posedge clock) begin
    pinReg <= wantStandby;
  end
endmodule
`default_nettype wire

// >>> test/svrs_voltage_select_bench.sv
// self-checking bench for the voltage select block
`timescale 1ns/1ns
`default_nettype none
module svrs_voltage_select_bench;
  import svrs_pkg::*;
  localparam int W = 5; // code width per rail
  localparam logic [7:0] HostWriteAddr = 8'h68; // serial write address the upstream decoder answers
  logic clock = 0, rst_b = 0, wantStandby = 0, pin, spareWrite = 0, hibernate = 0, keepAlive = 0, ce = 1;
  logic [3:0] runWr = 0, stbWr = 0, enReq = 0, railSlewing, railEnable;
  logic [4:0] wrData = 0;
  logic [7:0] spareData = 0, spareBits;
  logic [19:0] runLvl, stbLvl, railRef;
  int failures = 0, cmpCount = 0;
  always #50 clock = ~clock; // 10 MHz
  svrs_host_model i_host (.clock(clock), .wantStandby(wantStandby), .standbySelectPin(pin));
  // short step so slews finish in a few cycles
  svrs_voltage_select #(.STEP_CYCLES(2)) i_dut (.clock(clock), .rst_b(rst_b), .clockEnable(ce),
    .standbySelectPin(pin), .runLevelWrite(runWr), .standbyLevelWrite(stbWr), .levelWriteData(wrData),
    .spareWrite(spareWrite), .spareWriteData(spareData), .hibernate(hibernate), .bucKeepAliveSet(keepAlive),
    .bucEnableRequest(enReq), .runTargetLevel(runLvl), .standbyTargetLevel(stbLvl), .railReference(railRef),
    .railSlewing(railSlewing), .spareBits(spareBits), .railEnable(railEnable));
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmpCount, failures);
    if (failures == 0 && cmpCount > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [19:0] got, input logic [19:0] exp);
    cmpCount++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one-cycle strobe; run and standby share the data bus
  task automatic writeLevel(input logic [3:0] run, input logic [3:0] stb, input logic [4:0] code);
    runWr <= run;
    stbWr <= stb;
    wrData <= code;
    @(posedge clock);
    runWr <= 4'h0;
    stbWr <= 4'h0;
    @(posedge clock);
  endtask
  // host model adds one edge, so the pin lands on the first of the two edges waited
  task automatic setPin(input logic v);
    wantStandby <= v;
    repeat (2) @(posedge clock);
  endtask
  // bounded wait for a rail to stop, then check where it stopped
  task automatic settle(input int r, input logic [4:0] exp);
    for (int i = 0; i < 100 && railSlewing[r] !== 1'b0; i++) @(posedge clock);
    check(20'(railRef[W*r +: W]), 20'(exp));
  endtask
  initial begin
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    for (int r = 0; r < 4; r++) begin
      check(20'(runLvl[W*r +: W]), 20'h19);
      check(20'(stbLvl[W*r +: W]), 20'h19);
    end
    check(railRef, {4{5'h19}});
    setPin(1'b1);
    check(20'(railSlewing), 20'h0);
    setPin(1'b0);
    $display("test reset done");
    writeLevel(4'h0, 4'h1, 5'h15);
    writeLevel(4'h2, 4'h0, 5'h1f);
    check(20'(stbLvl[4:0]), 20'h15);
    check(20'(runLvl[9:5]), 20'h1f);
    settle(1, 5'h1f);
    setPin(1'b1);
    check(20'(railSlewing), 20'h3);
    settle(0, 5'h15);
    settle(1, 5'h19);
    setPin(1'b0);
    settle(0, 5'h19);
    settle(1, 5'h1f);
    $display("test slew done");
    // reverse mid-slew: only the final run levels are checked, not that the rail turned back
    setPin(1'b1);
    @(posedge clock);
    setPin(1'b0);
    settle(0, 5'h19);
    settle(1, 5'h1f);
    $display("test retarget done");
    // clock enable low must swallow a level write
    ce <= 1'b0;
    writeLevel(4'h1, 4'h0, 5'h10);
    ce <= 1'b1;
    check(20'(runLvl[4:0]), 20'h19);
    $display("test freeze done");
    spareData <= 8'ha5;
    spareWrite <= 1'b1;
    @(posedge clock);
    spareWrite <= 1'b0;
    @(posedge clock);
    check(20'(spareBits), 20'ha5);
    enReq <= 4'hf;
    keepAlive <= 1'b1;
    repeat (2) @(posedge clock);
    check(20'(railEnable), 20'hf);
    hibernate <= 1'b1;
    repeat (2) @(posedge clock);
    check(20'(railEnable), 20'h1);
    keepAlive <= 1'b0;
    // arm bit is registered first, so the drop shows one edge later
    repeat (3) @(posedge clock);
    check(20'(railEnable), 20'h0);
    $display("test spare and keep-alive done");
    summarize();
  end
  // whole run is under a hundred cycles; this is far beyond it
  initial begin
    #1000000;
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
